// ### hcm_config_control.sv
// Configuration-mode control: status/command register, reload and port power
//
// Operation
// - Bits seven to two read zero
// - Reset bit reloads configuration register defaults
// - Reset only in SMBus; sets config flag
// - Hardware clears reset bit; zero ignored
// - Config flag set on mode entry
// - Upstream connect held off while flag set
// - I2C exit clears config flag
// - Flag cleared by one in SMBus mode only; zero ignored
// - Unconnected polarity strap gives active high
// - Unconnected select strap gives I2C mode
// - Both straps low gives individual power
// - Pulled-up charge strap enables charging
module hcm_config_control
    import hcm_pkg::*;
(
    // Clock, reset and enable
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          ce,
    // Strap pins
    input  wire logic                          power_enable_polarity_strap,
    input  wire logic                          interface_select_strap,
    input  wire logic                          ganged_power_strap,
    input  wire logic                          power_management_strap,
    input  wire logic [hcm_pkg::NUM_PORTS-1:0] charge_enable_strap,
    // Register port from the serial target
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_rvalid,
    // I2C mode status from the configuration master
    input  wire logic                          i2c_mode_exit,
    // Hub core port power requests
    input  wire logic [hcm_pkg::NUM_PORTS-1:0] port_power_request,
    // Outputs to the hub
    output logic                               config_reload,
    output logic                               upstream_connect_allow,
    output logic                               smbus_mode,
    output logic                               individual_power_mode,
    output logic [hcm_pkg::NUM_PORTS-1:0]      port_power_enable,
    output logic [hcm_pkg::NUM_PORTS-1:0]      port_charge_enable
);
    import hcm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    hcm_strap_if   straps ();                   // Captured strap levels
    hcm_state_type state_r;                     // Sequencer state
    hcm_state_type state_nxt;                   // Next sequencer state
    logic          cfg_r;                       // Configuration-in-progress flag
    logic          cfg_nxt;                     // Next flag value
    logic          rst_req_r;                   // Interface reset request bit
    logic          rst_req_nxt;                 // Next request value
    logic [2:0]    reload_cnt_r;                // Reload progress counter
    logic          csc_hit;                     // Access targets our register
    logic          wr_cfg_clear;                // Host writes one to flag
    logic          wr_rst_set;                  // Accepted reset request
    logic          reload_last;                 // Final reload cycle
    logic          any_power;                   // Any port wants power

    ////////////////////////////////////////////////////////////////////////////
    // Strap sampler
    hcm_strap_sampler u_straps (
        .clk                         (clk),
        .reset                       (reset),
        .ce                          (ce),
        .power_enable_polarity_strap (power_enable_polarity_strap),
        .interface_select_strap      (interface_select_strap),
        .ganged_power_strap          (ganged_power_strap),
        .power_management_strap      (power_management_strap),
        .charge_enable_strap         (charge_enable_strap),
        .straps                      (straps)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    always_comb begin
        csc_hit      = 1'b0;
        wr_cfg_clear = 1'b0;
        wr_rst_set   = 1'b0;
        if (reg_addr == CSC_OFFSET) begin
            csc_hit = 1'b1;
        end
        wr_cfg_clear = csc_hit && reg_wr && reg_wdata[CSC_CFG_BIT];
        wr_rst_set   = csc_hit && reg_wr && reg_wdata[CSC_RST_BIT]
                       && !straps.i2c_mode
                       && (state_r == ST_CONFIG || state_r == ST_RUN);
    end

    // Last reload cycle
    assign reload_last = (reload_cnt_r == 3'(RELOAD_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SAMPLE: begin
                // Mode entered once straps are known
                if (straps.captured) begin
                    state_nxt = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (wr_rst_set) begin
                    state_nxt = ST_RELOAD;
                end else if (straps.i2c_mode && i2c_mode_exit) begin
                    state_nxt = ST_RUN;
                end else if (!straps.i2c_mode && wr_cfg_clear) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                // Only the interface reset returns to configuration
                if (wr_rst_set) begin
                    state_nxt = ST_RELOAD;
                end
            end
            ST_RELOAD: begin
                if (reload_last) begin
                    state_nxt = ST_CONFIG;
                end
            end
            default: begin
                state_nxt = ST_SAMPLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_SAMPLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration-in-progress flag
    always_comb begin
        cfg_nxt = cfg_r;
        if (state_r == ST_CONFIG && straps.i2c_mode && i2c_mode_exit) begin
            cfg_nxt = 1'b0;
        end else if (state_r == ST_CONFIG && wr_cfg_clear && !straps.i2c_mode) begin
            cfg_nxt = 1'b0;
        end
        // Sets below win over any clear in the same cycle
        if (state_r == ST_SAMPLE && straps.captured) begin
            cfg_nxt = 1'b1;
        end
        if (wr_rst_set || state_r == ST_RELOAD) begin
            cfg_nxt = 1'b1;
        end
    end

    // Flag register
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= CSC_RESET_VALUE[CSC_CFG_BIT];
        end else if (ce) begin
            cfg_r <= cfg_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interface reset request bit
    always_comb begin
        rst_req_nxt = rst_req_r;
        if (state_r == ST_RELOAD && reload_last) begin
            rst_req_nxt = 1'b0;
        end
        if (wr_rst_set) begin
            rst_req_nxt = 1'b1;
        end
    end

    // Request register
    always_ff @(posedge clk) begin
        if (reset) begin
            rst_req_r <= CSC_RESET_VALUE[CSC_RST_BIT];
        end else if (ce) begin
            rst_req_r <= rst_req_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reload counter and reload strobe to the other configuration registers
    always_ff @(posedge clk) begin
        if (reset) begin
            reload_cnt_r  <= 3'h0;
            config_reload <= 1'b0;
        end else if (ce) begin
            config_reload <= wr_rst_set;
            if (state_r == ST_RELOAD) begin
                reload_cnt_r <= reload_cnt_r + 3'h1;
            end else begin
                reload_cnt_r <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, one cycle latency
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata  <= CSC_RESET_VALUE;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd && csc_hit) begin
                reg_rdata <= {6'h00, rst_req_r, cfg_r};
            end else if (reg_rd) begin
                // Other offsets belong to other registers
                reg_rdata <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and connect outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            upstream_connect_allow <= 1'b0;
            smbus_mode             <= 1'b0;
            individual_power_mode  <= 1'b0;
            port_charge_enable     <= '0;
        end else if (ce) begin
            upstream_connect_allow <= straps.captured && !cfg_nxt;
            smbus_mode             <= straps.captured && !straps.i2c_mode;
            individual_power_mode  <= straps.individual_power;
            port_charge_enable     <= straps.charge_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port power enables with ganging and polarity
    assign any_power = |port_power_request;

    always_ff @(posedge clk) begin
        if (reset) begin
            port_power_enable <= '0;
        end else if (ce) begin
            if (!straps.captured) begin
                // All zero until the straps are captured, whatever the polarity
                port_power_enable <= '0;
            end else if (straps.individual_power) begin
                port_power_enable <= straps.pol_high ? port_power_request
                                                     : ~port_power_request;
            end else begin
                port_power_enable <= straps.pol_high ? {NUM_PORTS{any_power}}
                                                     : {NUM_PORTS{!any_power}};
            end
        end
    end

endmodule : hcm_config_control

// ### hcm_config_control_bench.sv
// Testbench for the configuration-mode control block
module hcm_config_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, reset, pol, sel, gang, pm, exit_p, reload, allow, smb, indiv, rv;
    logic [3:0] chg, req, ppe, pce;
    logic [7:0] addr, wdata, rdata;
    logic       wr, rd, ce;
    int         failures = 0;
    int         num_checks = 0;

    hcm_config_control dut (.clk(clk), .reset(reset), .ce(ce),
        .power_enable_polarity_strap(pol), .interface_select_strap(sel),
        .ganged_power_strap(gang), .power_management_strap(pm),
        .charge_enable_strap(chg), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv), .i2c_mode_exit(exit_p),
        .port_power_request(req), .config_reload(reload),
        .upstream_connect_allow(allow), .smbus_mode(smb),
        .individual_power_mode(indiv), .port_power_enable(ppe),
        .port_charge_enable(pce));
    hcm_host_model host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask : chk

    // Read the status byte and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        chk("rvalid", 8'h01, {7'h00, ok});
        chk("status", e, d);
    endtask : rchk

    // Reset with given straps, wait for capture
    task automatic do_reset(input logic s, input logic p, input logic g, input logic [3:0] c);
        sel = s;
        pol = p;
        gang = g;
        pm = g;
        chg = c;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        repeat (16) @(posedge clk);
        #1;
    endtask : do_reset

    // Serial bus mode: flag, clearing, interface reset
    task automatic test_smbus;
        do_reset(1'b0, 1'b1, 1'b0, 4'ha);
        rchk(8'hf8, 8'h01);
        chk("allow", 8'h00, {7'h00, allow});
        chk("indiv", 8'h01, {7'h00, indiv});
        chk("smb", 8'h01, {7'h00, smb});
        req = 4'h5;
        repeat (2) @(posedge clk);
        #1 chk("ppe", 8'h05, {4'h0, ppe});
        chk("pce", 8'h0a, {4'h0, pce});
        // Clear presented while frozen must not be taken
        ce = 1'b0;
        host.wr(8'hf8, 8'h01);
        ce = 1'b1;
        rchk(8'hf8, 8'h01);
        chk("allow", 8'h00, {7'h00, allow});
        host.wr(8'hf8, 8'h00);
        rchk(8'hf8, 8'h01);
        rchk(8'hf0, 8'h00);
        host.wr(8'hf8, 8'h01);
        rchk(8'hf8, 8'h00);
        chk("allow", 8'h01, {7'h00, allow});
        host.wr(8'hf8, 8'h02);
        chk("reload", 8'h01, {7'h00, reload});
        chk("allow", 8'h00, {7'h00, allow});
        repeat (6) @(posedge clk);
        rchk(8'hf8, 8'h01);
        host.wr(8'hf8, 8'h01);
        rchk(8'hf8, 8'h00);
        $display("smbus test done");
    endtask : test_smbus

    // I2C mode: ignored reset request, exit, ganged low polarity
    task automatic test_i2c;
        do_reset(1'b1, 1'b0, 1'b1, 4'h5);
        rchk(8'hf8, 8'h01);
        chk("smb", 8'h00, {7'h00, smb});
        chk("indiv", 8'h00, {7'h00, indiv});
        host.wr(8'hf8, 8'h02);
        chk("reload", 8'h00, {7'h00, reload});
        host.wr(8'hf8, 8'h01);
        rchk(8'hf8, 8'h01);
        chk("allow", 8'h00, {7'h00, allow});
        req = 4'h1;
        repeat (2) @(posedge clk);
        #1 chk("ppe", 8'h00, {4'h0, ppe});
        req = 4'h0;
        repeat (2) @(posedge clk);
        #1 chk("ppe", 8'h0f, {4'h0, ppe});
        chk("pce", 8'h05, {4'h0, pce});
        exit_p = 1'b1;
        @(posedge clk);
        #1 exit_p = 1'b0;
        rchk(8'hf8, 8'h00);
        chk("allow", 8'h01, {7'h00, allow});
        $display("i2c test done");
    endtask : test_i2c

    // Verdict and end of run
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        exit_p = 1'b0;
        req = 4'h0;
        test_smbus();
        test_i2c();
        end_sim();
    end

    // Watchdog, far beyond the hundred or fewer cycles needed
    initial begin
        #20000;
        failures++;
        end_sim();
    end
endmodule : hcm_config_control_bench

// ### hcm_config_properties.sv
// Checker for the configuration-mode control block
module hcm_config_properties
    import hcm_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 ce,
    // Straps
    input wire logic                 interface_select_strap,
    input wire logic                 ganged_power_strap,
    input wire logic                 power_management_strap,
    input wire logic [NUM_PORTS-1:0] charge_enable_strap,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_wr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    input wire logic                 reg_rvalid,
    input wire logic                 i2c_mode_exit,
    // Hub outputs
    input wire logic                 config_reload,
    input wire logic                 upstream_connect_allow,
    input wire logic                 smbus_mode,
    input wire logic                 individual_power_mode,
    input wire logic [NUM_PORTS-1:0] port_charge_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    // Reload pulse then four quiet cycles
    sequence reload_run;
        config_reload ##1 !config_reload [*4];
    endsequence

    upper_bits_zero_a: assert property (reg_rd && ce |=> reg_rvalid && reg_rdata[7:2] == 6'h00)
        else $error("read answer late or upper bits set");
    read_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");
    reload_cause_a: assert property (config_reload |-> $past(reg_wr && reg_wdata[CSC_RST_BIT] && reg_addr == CSC_OFFSET))
        else $error("reload without reset write");
    reload_length_a: assert property (config_reload |-> reload_run)
        else $error("reload pulse repeated too soon");
    reload_smbus_a: assert property (!smbus_mode |-> !config_reload)
        else $error("reload outside serial bus mode");
    reload_holds_a: assert property (config_reload |-> !upstream_connect_allow)
        else $error("connect allowed during reload");
    connect_cause_a: assert property ($rose(upstream_connect_allow) |-> $past(i2c_mode_exit) || $past(reg_wr && reg_wdata[CSC_CFG_BIT] && smbus_mode && reg_addr == CSC_OFFSET))
        else $error("connect allowed without clearing");
    mode_strap_a: assert property (smbus_mode |-> !interface_select_strap)
        else $error("bus mode against select strap");
    power_mode_a: assert property (individual_power_mode |-> !ganged_power_strap && !power_management_strap)
        else $error("individual power against straps");
    charge_map_a: assert property (port_charge_enable != 4'h0 |-> port_charge_enable == charge_enable_strap)
        else $error("charge enables differ from straps");
endmodule : hcm_config_properties

bind hcm_config_control hcm_config_properties u_props (.clk, .reset, .ce,
    .interface_select_strap, .ganged_power_strap, .power_management_strap,
    .charge_enable_strap, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .i2c_mode_exit, .config_reload, .upstream_connect_allow,
    .smbus_mode, .individual_power_mode, .port_charge_enable);

// ### hcm_host_model.sv
// Host controller model driving the register port
module hcm_host_model (
    // Clock
    input wire logic       clk,
    // Register port
    output logic     [7:0] reg_addr,
    output logic           reg_wr,
    output logic     [7:0] reg_wdata,
    output logic           reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One byte write; lines scrambled when released
    // Write strobe held high for one clock
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One byte read; answer taken just after the accepting edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 d = reg_rdata;
        ok = reg_rvalid;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
endmodule : hcm_host_model

// ### hcm_pkg.sv
// Package of constants and types for the hub configuration-mode control block
package hcm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] CSC_OFFSET      = 8'hf8;  // Status and command register
    localparam logic [7:0] CSC_RESET_VALUE = 8'h00;  // Value after global reset
    localparam int         CSC_CFG_BIT     = 0;      // Configuration-in-progress flag
    localparam int         CSC_RST_BIT     = 1;      // Interface reset request
    localparam int         CSC_UNUSED_LSB  = 2;      // Low end of unused bits
    localparam int         CSC_UNUSED_MSB  = 7;      // High end of unused bits

    ////////////////////////////////////////////////////////////////////////////
    // Timing constants
    localparam int RELOAD_CYCLES = 4;   // Cycles the register reload takes
    localparam int SETTLE_CYCLES = 8;   // Cycles before straps are captured

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_PORTS = 4;       // Downstream ports

    // Control sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_SAMPLE = 4'b0001,            // Waiting for straps to be captured
        ST_CONFIG = 4'b0010,            // Configuration in progress
        ST_RUN    = 4'b0100,            // Configuration finished
        ST_RELOAD = 4'b1000             // Reloading configuration registers
    } hcm_state_type;

endpackage : hcm_pkg

// ### hcm_strap_if.sv
// Interface carrying captured strap levels between the strap sampler and the control
interface hcm_strap_if;
    logic       captured;               // Straps have been captured
    logic       pol_high;               // Power enables active high
    logic       i2c_mode;               // Strap selects I2C mode
    logic       individual_power;       // Per-port power control
    logic [3:0] charge_en;              // Per-port battery charging enable

    modport producer (output captured, pol_high, i2c_mode, individual_power, charge_en);
    modport consumer (input  captured, pol_high, i2c_mode, individual_power, charge_en);
endinterface : hcm_strap_if

// ### hcm_strap_sampler.sv
// Strap synchroniser and capture after reset release
module hcm_strap_sampler
    import hcm_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    // Raw strap pins
    input  wire logic                 power_enable_polarity_strap,
    input  wire logic                 interface_select_strap,
    input  wire logic                 ganged_power_strap,
    input  wire logic                 power_management_strap,
    input  wire logic [NUM_PORTS-1:0] charge_enable_strap,
    // Captured levels
    hcm_strap_if.producer             straps
);
    import hcm_pkg::*;

    localparam int W = NUM_PORTS + 4;   // Strap bits in total

    logic [W-1:0] sync1_r;              // First synchroniser stage
    logic [W-1:0] sync2_r;              // Second synchroniser stage
    logic [3:0]   settle_r;             // Settling counter

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser, no reset needed on data
    always_ff @(posedge clk) begin
        if (ce) begin
            sync1_r <= {charge_enable_strap, power_management_strap,
                        ganged_power_strap, interface_select_strap,
                        power_enable_polarity_strap};
            sync2_r <= sync1_r;
        end
    end

    // Settle count, then capture once after reset release
    always_ff @(posedge clk) begin
        if (reset) begin
            settle_r         <= 4'h0;
            straps.captured  <= 1'b0;
            straps.pol_high  <= 1'b1;
            straps.i2c_mode  <= 1'b1;
            straps.individual_power <= 1'b0;
            straps.charge_en <= '0;
        end else if (ce && !straps.captured) begin
            if (settle_r == 4'(SETTLE_CYCLES - 1)) begin
                straps.captured <= 1'b1;
                straps.pol_high <= sync2_r[0];
                straps.i2c_mode <= sync2_r[1];
                straps.individual_power <= !sync2_r[2] && !sync2_r[3];
                straps.charge_en <= sync2_r[W-1:4];
            end else begin
                settle_r <= settle_r + 4'h1;
            end
        end
    end

endmodule : hcm_strap_sampler
